// *** rtl/mmd_pkg.sv ***
// Constants for the memory map decoder
package mmd_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] VEC_LO = 16'h0000;
    localparam logic [15:0] VEC_HI = 16'h003F;
    localparam logic [15:0] TCALL_LO = 16'h0040;
    localparam logic [15:0] TCALL_HI = 16'h007F;
    localparam logic [15:0] FCALL_LO = 16'h0800;
    localparam logic [15:0] FCALL_HI = 16'h0FFF;
    localparam logic [15:0] ROM_HI = 16'hEFFF;
    localparam logic [15:0] XRAM_LO = 16'hF400;
    localparam logic [15:0] XRAM_HI = 16'hF7DF;
    localparam logic [15:0] DISP_LO = 16'hFA58;
    localparam logic [15:0] DISP_HI = 16'hFA7F;
    localparam logic [15:0] HRAM_LO = 16'hFB00;
    localparam logic [15:0] HRAM_HI = 16'hFEFF;
    localparam logic [15:0] GREG_LO = 16'hFEE0;
    localparam logic [15:0] SFR_LO = 16'hFF00;
    localparam logic [15:0] SFR_HI = 16'hFFFF;
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] VEC_BRK = 16'h003E;
    localparam logic [7:0] REGION_NONE = 8'h00;
    // Bit positions in the one-hot region select
    localparam int R_ROM = 0;
    localparam int R_XRAM = 1;
    localparam int R_DISP = 2;
    localparam int R_HRAM = 3;
    localparam int R_SFR = 4;
    localparam int R_EXT = 5;
    localparam int R_UNMAP = 6;
    localparam int NREG = 7;
endpackage

// *** rtl/mmd_range.sv ***
// Inclusive address range compare
`timescale 1ns/1ps
module mmd_range #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'hFFFF
) (
    // Address in
    input wire logic [15:0] addr,
    // Hit out
    output logic hit
);
    // Range test
    assign hit = (addr >= LO) && (addr <= HI);
endmodule

// *** rtl/mmd_memory_map_decoder.sv ***
// Memory map decoder for a 64K-byte CPU address space
`timescale 1ns/1ps
module mmd_memory_map_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CPU address request
    input wire logic req,
    input wire logic fetch,
    input wire logic [15:0] addr,
    input wire logic fixed_area_call,
    input wire logic table_call_one_byte,
    // Vector lookup request
    input wire logic vec_req,
    input wire logic [4:0] vec_index,
    // Memory expansion mode enable
    input wire logic ext_enable,
    // Region selects, one-hot
    output logic [6:0] region,
    output logic valid,
    // Program area flags
    output logic in_vector,
    output logic in_table_call,
    output logic in_fixed_call,
    output logic call_target_bad,
    // Data area details
    output logic in_gen_reg,
    output logic [1:0] gen_bank,
    output logic [2:0] gen_reg,
    output logic [9:0] hram_index,
    output logic [5:0] disp_index,
    output logic [9:0] xram_index,
    output logic [7:0] sfr_index,
    output logic fetch_fault,
    // Vector byte addresses
    output logic vec_valid,
    output logic [15:0] vec_lo_addr,
    output logic [15:0] vec_hi_addr
);
    ////////////////////////////////////////////////////////////////////
    // Range detectors
    logic h_vec, h_ct, h_cf, h_rom, h_xram, h_disp, h_hram, h_greg, h_sfr;
    mmd_range #(.LO(mmd_pkg::VEC_LO), .HI(mmd_pkg::VEC_HI)) u_vec (.addr(addr), .hit(h_vec));
    mmd_range #(.LO(mmd_pkg::TCALL_LO), .HI(mmd_pkg::TCALL_HI)) u_ct (.addr(addr), .hit(h_ct));
    mmd_range #(.LO(mmd_pkg::FCALL_LO), .HI(mmd_pkg::FCALL_HI)) u_cf (.addr(addr), .hit(h_cf));
    mmd_range #(.LO(mmd_pkg::VEC_LO), .HI(mmd_pkg::ROM_HI)) u_rom (.addr(addr), .hit(h_rom));
    mmd_range #(.LO(mmd_pkg::XRAM_LO), .HI(mmd_pkg::XRAM_HI)) u_xr (.addr(addr), .hit(h_xram));
    mmd_range #(.LO(mmd_pkg::DISP_LO), .HI(mmd_pkg::DISP_HI)) u_dp (.addr(addr), .hit(h_disp));
    mmd_range #(.LO(mmd_pkg::HRAM_LO), .HI(mmd_pkg::HRAM_HI)) u_hr (.addr(addr), .hit(h_hram));
    mmd_range #(.LO(mmd_pkg::GREG_LO), .HI(mmd_pkg::HRAM_HI)) u_gr (.addr(addr), .hit(h_greg));
    mmd_range #(.LO(mmd_pkg::SFR_LO), .HI(mmd_pkg::SFR_HI)) u_sf (.addr(addr), .hit(h_sfr));

    ////////////////////////////////////////////////////////////////////
    // Exactly one region per address, external only when enabled
    logic [6:0] next_region;
    logic h_gap;
    assign h_gap = !(h_rom || h_xram || h_disp || h_hram || h_sfr);
    always_comb begin
        next_region = mmd_pkg::REGION_NONE[6:0];
        if (h_rom) begin
            next_region[mmd_pkg::R_ROM] = 1'b1;
        end else if (h_xram) begin
            next_region[mmd_pkg::R_XRAM] = 1'b1;
        end else if (h_disp) begin
            next_region[mmd_pkg::R_DISP] = 1'b1;
        end else if (h_hram) begin
            next_region[mmd_pkg::R_HRAM] = 1'b1;
        end else if (h_sfr) begin
            next_region[mmd_pkg::R_SFR] = 1'b1;
        end else if (ext_enable) begin
            next_region[mmd_pkg::R_EXT] = 1'b1;
        end else begin
            next_region[mmd_pkg::R_UNMAP] = 1'b1;
        end
    end

    // Registered region select; every address accepted
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            region <= 7'h00;
            valid <= 1'b0;
        end else begin
            region <= req ? next_region : 7'h00;
            valid <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program memory area flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_vector <= 1'b0;
            in_table_call <= 1'b0;
            in_fixed_call <= 1'b0;
            call_target_bad <= 1'b0;
        end else begin
            in_vector <= req && h_vec;
            in_table_call <= req && h_ct;
            in_fixed_call <= req && h_cf;
            call_target_bad <= req && ((fixed_area_call && !h_cf)
                || (table_call_one_byte && !h_ct));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data area indices and fetch fault
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_gen_reg <= 1'b0;
            gen_bank <= 2'h0;
            gen_reg <= 3'h0;
            hram_index <= 10'h000;
            disp_index <= 6'h00;
            xram_index <= 10'h000;
            sfr_index <= 8'h00;
            fetch_fault <= 1'b0;
        end else begin
            in_gen_reg <= req && h_greg;
            gen_bank <= addr[4:3];
            gen_reg <= addr[2:0];
            hram_index <= 10'(addr - mmd_pkg::HRAM_LO);
            disp_index <= 6'(addr - mmd_pkg::DISP_LO);
            xram_index <= 10'(addr - mmd_pkg::XRAM_LO);
            sfr_index <= addr[7:0];
            fetch_fault <= req && fetch && h_xram;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Vector byte addresses, reset vector after reset release
    logic first;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first <= 1'b1;
            vec_valid <= 1'b0;
            vec_lo_addr <= 16'h0000;
            vec_hi_addr <= 16'h0000;
        end else begin
            first <= 1'b0;
            vec_valid <= first || vec_req;
            if (first) begin
                vec_lo_addr <= mmd_pkg::RESET_VEC;
                vec_hi_addr <= mmd_pkg::RESET_VEC | 16'h0001;
            end else if (vec_req) begin
                vec_lo_addr <= {10'h000, vec_index, 1'b0};
                vec_hi_addr <= {10'h000, vec_index, 1'b1};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    chk_one_region: assert property (@(posedge clk) disable iff (rst)
        valid |-> $onehot(region)) else $error("region not one-hot");
    chk_xram_fetch: assert property (@(posedge clk) disable iff (rst)
        req && fetch && addr >= mmd_pkg::XRAM_LO && addr <= mmd_pkg::XRAM_HI
        |=> fetch_fault) else $error("xram fetch not flagged");
    chk_fetch_clean: assert property (@(posedge clk) disable iff (rst)
        req && !(addr >= mmd_pkg::XRAM_LO && addr <= mmd_pkg::XRAM_HI)
        |=> !fetch_fault) else $error("fetch fault outside xram");
    chk_sfr_route: assert property (@(posedge clk) disable iff (rst)
        req && addr >= mmd_pkg::SFR_LO |=> region[mmd_pkg::R_SFR])
        else $error("sfr not routed");
    chk_ext_gate: assert property (@(posedge clk) disable iff (rst)
        req && !ext_enable |=> !region[mmd_pkg::R_EXT])
        else $error("external without enable");
    // Unclaimed gaps go external once expansion is enabled
    chk_gap_ext: assert property (@(posedge clk) disable iff (rst)
        req && h_gap && ext_enable |=> region[mmd_pkg::R_EXT])
        else $error("gap not routed external");
    chk_hram_range: assert property (@(posedge clk) disable iff (rst)
        req && addr >= mmd_pkg::HRAM_LO && addr <= mmd_pkg::HRAM_HI
        |=> region[mmd_pkg::R_HRAM] && hram_index == 10'($past(addr) - mmd_pkg::HRAM_LO))
        else $error("hram decode wrong");
    chk_disp_range: assert property (@(posedge clk) disable iff (rst)
        req && addr >= mmd_pkg::DISP_LO && addr <= mmd_pkg::DISP_HI
        |=> region[mmd_pkg::R_DISP] && disp_index == 6'($past(addr) - mmd_pkg::DISP_LO))
        else $error("display decode wrong");
    chk_xram_range: assert property (@(posedge clk) disable iff (rst)
        req && addr >= mmd_pkg::XRAM_LO && addr <= mmd_pkg::XRAM_HI
        |=> region[mmd_pkg::R_XRAM] && xram_index == 10'($past(addr) - mmd_pkg::XRAM_LO))
        else $error("xram decode wrong");
    chk_vec_pair: assert property (@(posedge clk) disable iff (rst)
        vec_valid |-> vec_hi_addr == (vec_lo_addr | 16'h0001) && !vec_lo_addr[0])
        else $error("vector byte pair wrong");
    // Reset vector shown on the edge after the first one out of reset
    chk_reset_vec: assert property (@(posedge clk) disable iff (rst)
        first |=> vec_valid && vec_lo_addr == mmd_pkg::RESET_VEC)
        else $error("reset vector missing");
    // Vector lookup steps: request taken, then its entry address shown
    sequence s_vec_taken;
        vec_req && !first;
    endsequence
    sequence s_vec_shown;
        vec_valid && vec_lo_addr <= mmd_pkg::VEC_HI && vec_lo_addr[5:1] == $past(vec_index);
    endsequence
    chk_vec_lookup: assert property (@(posedge clk) disable iff (rst)
        s_vec_taken |=> s_vec_shown) else $error("vector lookup wrong");
    chk_vec_area: assert property (@(posedge clk) disable iff (rst)
        req && addr <= mmd_pkg::VEC_HI |=> in_vector && region[mmd_pkg::R_ROM])
        else $error("vector area missed");
    chk_fcall_bad: assert property (@(posedge clk) disable iff (rst)
        req && fixed_area_call && addr < mmd_pkg::FCALL_LO |=> call_target_bad)
        else $error("fixed call target not flagged");
    chk_tcall_bad: assert property (@(posedge clk) disable iff (rst)
        req && table_call_one_byte && addr > mmd_pkg::TCALL_HI |=> call_target_bad)
        else $error("table call target not flagged");
    chk_greg_bank: assert property (@(posedge clk) disable iff (rst)
        req && addr >= mmd_pkg::GREG_LO && addr <= mmd_pkg::HRAM_HI
        |=> in_gen_reg && gen_bank == $past(addr[4:3]))
        else $error("register bank wrong");
endmodule

// *** verification/mmd_cpu_model.sv ***
// CPU core model issuing fetch, data, call and vector requests
`timescale 1ns/1ps
module mmd_cpu_model (
    // Clock
    input wire logic clk,
    // Request lines
    output logic req,
    output logic fetch,
    output logic [15:0] addr,
    output logic fixed_area_call,
    output logic table_call_one_byte,
    output logic vec_req,
    output logic [4:0] vec_index,
    output logic ext_enable
);
    // Idle at time zero
    initial begin
        {req, fetch, fixed_area_call, table_call_one_byte, vec_req, ext_enable} = 6'h00;
        addr = 16'h0000;
        vec_index = 5'h00;
    end
    ////////////////////////////////////////////////////////////////
    // One access, then release with inverted address
    task automatic issue(input logic [15:0] a, input logic [2:0] kind);
        @(negedge clk);
        req = 1'b1;
        addr = a;
        {fetch, fixed_area_call, table_call_one_byte} = kind;
        @(negedge clk);
        req = 1'b0;
        addr = ~a;
        {fetch, fixed_area_call, table_call_one_byte} = 3'h0;
    endtask
    // One vector lookup pulse
    task automatic lookup(input logic [4:0] idx);
        @(negedge clk);
        vec_req = 1'b1;
        vec_index = idx;
        @(negedge clk);
        vec_req = 1'b0;
        vec_index = ~idx;
    endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, req, fetch, fixed_area_call, table_call_one_byte, vec_req, ext_enable;
    logic valid, in_vector, in_table_call, in_fixed_call, call_target_bad;
    logic in_gen_reg, fetch_fault, vec_valid;
    logic [15:0] addr, vec_lo_addr, vec_hi_addr;
    logic [9:0] hram_index, xram_index;
    logic [7:0] sfr_index;
    logic [6:0] region;
    logic [5:0] disp_index;
    logic [4:0] vec_index;
    logic [2:0] gen_reg;
    logic [1:0] gen_bank;
    int mismatches, check_count;
    // Design and CPU model
    mmd_memory_map_decoder u_mmd_memory_map_decoder (.clk, .rst, .req, .fetch, .addr,
        .fixed_area_call, .table_call_one_byte, .vec_req, .vec_index, .ext_enable, .region,
        .valid, .in_vector, .in_table_call, .in_fixed_call, .call_target_bad, .in_gen_reg,
        .gen_bank, .gen_reg, .hram_index, .disp_index, .xram_index, .sfr_index, .fetch_fault,
        .vec_valid, .vec_lo_addr, .vec_hi_addr);
    mmd_cpu_model u_mmd_cpu_model (.clk, .req, .fetch, .addr, .fixed_area_call,
        .table_call_one_byte, .vec_req, .vec_index, .ext_enable);
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Expected one-hot region
    function automatic logic [6:0] exp_region(input logic [15:0] a, input logic e);
        if (a <= 16'hEFFF) return 7'h01;
        if (a >= 16'hF400 && a <= 16'hF7DF) return 7'h02;
        if (a >= 16'hFA58 && a <= 16'hFA7F) return 7'h04;
        if (a >= 16'hFB00 && a <= 16'hFEFF) return 7'h08;
        if (a >= 16'hFF00) return 7'h10;
        return e ? 7'h20 : 7'h40;
    endfunction
    ////////////////////////////////////////////////////////////////
    // Reset for 8 cycles, then reset vector
    task automatic t_reset();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(vec_valid, 1'b1);
        chk({vec_hi_addr, vec_lo_addr}, 32'h0001_0000);
        chk({valid, region}, 8'h00);
    endtask
    // Region boundaries, ext off with data, ext on with fetch
    task automatic t_regions();
        logic [15:0] al[23] = '{16'h0000, 16'h003F, 16'h0040, 16'h007F, 16'h0800, 16'h0FFF,
            16'hEFFF, 16'hF000, 16'hF3FF, 16'hF400, 16'hF7DF, 16'hF7E0, 16'hFA57, 16'hFA58,
            16'hFA7F, 16'hFA80, 16'hFAFF, 16'hFB00, 16'hFEDF, 16'hFEE0, 16'hFEFF, 16'hFF00,
            16'hFF2D};
        logic [15:0] a;
        logic [6:0] er;
        for (int e = 0; e < 2; e++) begin
            u_mmd_cpu_model.ext_enable = e[0];
            foreach (al[i]) begin
                a = al[i];
                er = exp_region(a, e[0]);
                u_mmd_cpu_model.issue(a, {e[0], 2'h0});
                chk(valid, 1'b1);
                chk(region, er);
                chk(fetch_fault, e[0] && er[1]);
                chk(in_vector, a <= 16'h003F);
                chk(in_table_call, a >= 16'h0040 && a <= 16'h007F);
                chk(in_fixed_call, a >= 16'h0800 && a <= 16'h0FFF);
                chk(in_gen_reg, a >= 16'hFEE0 && a <= 16'hFEFF);
                if (a >= 16'hFEE0 && a <= 16'hFEFF) chk({gen_bank, gen_reg}, a[4:0]);
                if (er[1]) chk(xram_index, a - 16'hF400);
                if (er[2]) chk(disp_index, a - 16'hFA58);
                if (er[3]) chk(hram_index, a - 16'hFB00);
                if (er[4]) chk(sfr_index, a[7:0]);
            end
        end
    endtask
    // Call targets at and beyond the edges of both call areas
    task automatic t_calls();
        logic [15:0] al[8] = '{16'h0800, 16'h0FFF, 16'h07FF, 16'h1000, 16'h0040, 16'h007F,
            16'h003F, 16'h0080};
        foreach (al[i]) begin
            u_mmd_cpu_model.issue(al[i], i < 4 ? 3'h2 : 3'h1);
            chk(call_target_bad, i[1]);
        end
    endtask
    // Vector lookups, then the pulse drops
    task automatic t_vectors();
        logic [4:0] il[3] = '{5'h02, 5'h1F, 5'h00};
        foreach (il[i]) begin
            u_mmd_cpu_model.lookup(il[i]);
            chk(vec_valid, 1'b1);
            chk({vec_hi_addr, vec_lo_addr}, {16'(il[i]) * 16'h0002 + 16'h0001,
                16'(il[i]) * 16'h0002});
        end
        @(negedge clk);
        chk(vec_valid, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        t_reset();
        t_regions();
        t_calls();
        t_vectors();
        t_reset();
        t_vectors();
        give_verdict();
    end
endmodule
